/* File: rtl/sdh_regs.sv */
// Register bank, card clock generator and block chunker of the card host
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Writing one to clear bit clears source
// RQ2: Zero or upper bits leave sources alone
// RQ3: Disable bit stops clock, output held low
// RQ4: Rate register resets with disable set
// RQ5: Software programs divider before enabling clock
// RQ6: Software stops clock before changing divider
// RQ7: Card clock is PLL clock over divider
// RQ8: Only divider two or more runs clock
// RQ9: Output clock delayed by delay field taps
// RQ10: Width code gives one, four, eight lines
// RQ11: Tx size code sets write access width
// RQ12: Rx size code sets read access width
// RQ13: Software flushes fifo after width change
// RQ14: Enable clear holds interface inoperative
// RQ15: Block size is two to the n; code gives zero bytes for n of zero
// RQ16: Long transfers split into block chunks
// RQ17: Mask register gates each source, one masks
// RQ18: Clock changes applied only in low phase
module sdh_regs #(
  parameter int NSRC = sdh_pkg::NSRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NSRC-1:0] src_evt_i,
  output logic irq_o,
  output logic card_clk_o,
  output sdh_pkg::sdh_cfg_t cfg_o,
  output logic [3:0] card_lines_o,
  output logic [16:0] blk_bytes_o,
  input wire sdh_pkg::sdh_xfer_t xfer_i,
  output logic blk_end_o,
  output logic xfer_done_o,
  output logic xfer_busy_o
);
  // ****************************
  // State
  // ****************************
  typedef struct packed {
    logic ack; // Bus answer
    logic [31:0] dat; // Read data
    logic [NSRC-1:0] raw; // Latched sources
    logic [NSRC-1:0] mask; // Source mask
    logic irq; // Interrupt level
    logic dis; // Clock disable
    logic [3:0] dly; // Output delay taps
    logic [15:0] div; // Programmed divider
    sdh_pkg::sdh_cfg_t cfg; // Configuration
    logic [15:0] adiv; // Divider in use
    logic [15:0] cnt; // Divider phase
    logic run; // Clock running
    logic sclk; // Undelayed card clock
    logic [sdh_pkg::DLY_TAPS-1:0] line; // Delay line
    logic cko; // Delayed card clock
    logic [3:0] lanes; // Active data lines
    logic [16:0] bsize; // Block bytes
    logic [16:0] bcnt; // Bytes in block
    logic [15:0] left; // Bytes left
    logic busy; // Transfer in progress
    logic blk_end; // Block boundary pulse
    logic done; // Transfer end pulse
  } sdh_st_t;

  sdh_st_t st_r; // Registered state
  sdh_st_t st_nxt; // Next state
  logic req; // Bus request present
  logic wr; // Write takes effect now
  logic [31:0] wm; // Byte lane mask
  logic [NSRC-1:0] clr; // Clear strobes
  logic [31:0] rate_rd; // Rate register view
  logic [31:0] cfg_rd; // Config register view
  logic wrap; // End of a low phase

  // Bus decode helpers
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    wr = req & wb_we_i & st_r.ack;
    wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    clr = '0;
    if (wr && wb_adr_i == sdh_pkg::ADR_CLR) begin
      clr = wb_dat_i[NSRC-1:0] & wm[NSRC-1:0]; // RQ1 RQ2
    end
    rate_rd = '0;
    rate_rd[sdh_pkg::RATE_DIS] = st_r.dis;
    rate_rd[sdh_pkg::RATE_DLY +: 4] = st_r.dly;
    rate_rd[sdh_pkg::RATE_DIV +: 16] = st_r.div;
    cfg_rd = '0;
    cfg_rd[sdh_pkg::CFG_DW +: 2] = st_r.cfg.dw;
    cfg_rd[sdh_pkg::CFG_TXS +: 2] = st_r.cfg.txs;
    cfg_rd[sdh_pkg::CFG_RXS +: 2] = st_r.cfg.rxs;
    cfg_rd[sdh_pkg::CFG_EN] = st_r.cfg.en;
    cfg_rd[sdh_pkg::CFG_BS +: 4] = st_r.cfg.bs;
    wrap = st_r.cnt == st_r.adiv - 16'h0001;
  end

  // ****************************
  // Next state
  // ****************************
  always_comb begin
    logic [31:0] nv;
    nv = '0;
    st_nxt = st_r;
    // Bus answer one cycle after request, then dropped
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      case (wb_adr_i)
        sdh_pkg::ADR_RAW: st_nxt.dat = 32'(st_r.raw);
        sdh_pkg::ADR_MASK: st_nxt.dat = 32'(st_r.mask);
        sdh_pkg::ADR_RATE: st_nxt.dat = rate_rd;
        sdh_pkg::ADR_CFG: st_nxt.dat = cfg_rd;
        default: st_nxt.dat = 32'h00000000; // Clear and unmapped read zero
      endcase
    end
    // Register writes with byte lanes
    if (wr) begin
      case (wb_adr_i)
        sdh_pkg::ADR_MASK: begin
          nv = (32'(st_r.mask) & ~wm) | (wb_dat_i & wm);
          st_nxt.mask = nv[NSRC-1:0]; // RQ17
        end
        sdh_pkg::ADR_RATE: begin
          nv = (rate_rd & ~wm) | (wb_dat_i & wm);
          st_nxt.dis = nv[sdh_pkg::RATE_DIS];
          st_nxt.dly = nv[sdh_pkg::RATE_DLY +: 4];
          st_nxt.div = nv[sdh_pkg::RATE_DIV +: 16];
        end
        sdh_pkg::ADR_CFG: begin
          nv = (cfg_rd & ~wm) | (wb_dat_i & wm);
          st_nxt.cfg.dw = nv[sdh_pkg::CFG_DW +: 2];
          st_nxt.cfg.txs = nv[sdh_pkg::CFG_TXS +: 2]; // RQ11
          st_nxt.cfg.rxs = nv[sdh_pkg::CFG_RXS +: 2]; // RQ12
          st_nxt.cfg.en = nv[sdh_pkg::CFG_EN];
          st_nxt.cfg.bs = nv[sdh_pkg::CFG_BS +: 4];
        end
        default: begin
          nv = '0; // Raw, clear and unmapped keep no state
        end
      endcase
    end
    // Sticky sources, a new event wins over a clear
    st_nxt.raw = (st_r.raw & ~clr) | src_evt_i; // RQ1 RQ2
    st_nxt.irq = |(st_nxt.raw & ~st_nxt.mask); // RQ17
    // Card clock: reload only while stopped or at end of low phase
    if (!st_r.run || wrap) begin
      st_nxt.cnt = 16'h0000; // RQ18
      st_nxt.adiv = st_r.div; // RQ7
      st_nxt.run = !st_r.dis && st_r.cfg.en && st_r.div >= sdh_pkg::DIV_MIN; // RQ3 RQ8 RQ14
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    // High for the first half of each period
    st_nxt.sclk = st_nxt.run && st_nxt.cnt < (st_nxt.adiv >> 1); // RQ7 RQ3
    // Delay line toward the pin
    st_nxt.line = {st_r.line[sdh_pkg::DLY_TAPS-2:0], st_r.sclk};
    if (st_r.dly == 4'h0) begin
      st_nxt.cko = st_r.sclk; // RQ9
    end else begin
      st_nxt.cko = st_r.line[st_r.dly - 4'h1]; // RQ9
    end
    // Data lines from width code
    case (st_nxt.cfg.dw)
      2'h0: st_nxt.lanes = 4'h1; // RQ10
      2'h1: st_nxt.lanes = 4'h4; // RQ10
      2'h2: st_nxt.lanes = 4'h8; // RQ10
      default: st_nxt.lanes = 4'h0; // Reserved code
    endcase
    // Block size, reserved code reads zero bytes
    if (st_nxt.cfg.bs == 4'h0) begin
      st_nxt.bsize = 17'h00000; // RQ15
    end else begin
      st_nxt.bsize = 17'h00001 << st_nxt.cfg.bs; // RQ15
    end
    // Chunking of a transfer into blocks
    st_nxt.blk_end = 1'b0;
    st_nxt.done = 1'b0;
    if (!st_r.cfg.en) begin
      st_nxt.busy = 1'b0; // RQ14
      st_nxt.bcnt = 17'h00000;
    end else if (xfer_i.start && xfer_i.len != 16'h0000) begin
      st_nxt.busy = 1'b1;
      st_nxt.left = xfer_i.len;
      st_nxt.bcnt = 17'h00000;
    end else if (st_r.busy && xfer_i.step) begin
      st_nxt.left = st_r.left - 16'h0001;
      st_nxt.bcnt = st_r.bcnt + 17'h00001;
      if (st_r.bcnt + 17'h00001 >= st_r.bsize || st_r.left == 16'h0001) begin
        st_nxt.blk_end = 1'b1; // RQ16
        st_nxt.bcnt = 17'h00000;
      end
      if (st_r.left == 16'h0001) begin
        st_nxt.done = 1'b1;
        st_nxt.busy = 1'b0;
      end
    end
  end

  // ****************************
  // State register
  // ****************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.mask <= sdh_pkg::MASK_RST[NSRC-1:0];
      st_r.dis <= sdh_pkg::RATE_RST[sdh_pkg::RATE_DIS]; // RQ4
      st_r.dly <= sdh_pkg::RATE_RST[sdh_pkg::RATE_DLY +: 4];
      st_r.div <= sdh_pkg::RATE_RST[sdh_pkg::RATE_DIV +: 16];
      st_r.cfg <= sdh_pkg::CFG_RST[10:0];
      st_r.lanes <= 4'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign irq_o = st_r.irq;
  assign card_clk_o = st_r.cko;
  assign cfg_o = st_r.cfg;
  assign card_lines_o = st_r.lanes;
  assign blk_bytes_o = st_r.bsize;
  assign blk_end_o = st_r.blk_end;
  assign xfer_done_o = st_r.done;
  assign xfer_busy_o = st_r.busy;

  // ****************************
  // Checks
  // ****************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus request then one-cycle answer
  sequence s_req;
    req && !st_r.ack;
  endsequence
  sequence s_ans;
    st_r.ack ##1 !st_r.ack;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  a_clr_source: assert property ( // RQ1
    wr && wb_adr_i == sdh_pkg::ADR_CLR && wb_dat_i[0] && wb_sel_i[0] && !src_evt_i[0]
    |=> !st_r.raw[0])
    else $error("clear did not clear source");
  a_raw_keep: assert property ( // RQ2
    1'b1 |=> ((~st_r.raw) & $past(st_r.raw) & ~$past(clr)) == '0)
    else $error("source lost without clear");
  a_reset_rate: assert property ( // RQ4
    $past(rst_i) |-> st_r.dis && !st_r.run && !card_clk_o)
    else $error("clock not stopped after reset");
  a_stop_low: assert property ( // RQ3
    (!st_r.run)[*8] ##1 (!st_r.run)[*8] |=> !card_clk_o)
    else $error("card clock not held low");
  a_div_wrap: assert property ( // RQ7
    st_r.run && wrap |=> st_r.cnt == 16'h0000 && st_r.adiv == $past(st_r.div))
    else $error("divider did not wrap");
  a_div_valid: assert property ( // RQ8
    st_r.run |-> st_r.adiv >= sdh_pkg::DIV_MIN)
    else $error("clock runs with bad divide");
  a_high_full: assert property ( // RQ18
    $fell(st_r.sclk) |-> st_r.cnt == (st_r.adiv >> 1))
    else $error("shortened high phase");
  a_dly_tap: assert property ( // RQ9
    st_r.dly == 4'h3 && $rose(st_r.sclk) ##1 st_r.dly == 4'h3 [*3] |=> st_r.cko)
    else $error("delay tap wrong");
  a_en_idle: assert property ( // RQ14
    !st_r.cfg.en |=> !st_r.busy && (!st_r.run || !$past(!st_r.run || wrap)))
    else $error("interface active while disabled");
  a_blk_split: assert property ( // RQ16
    st_r.cfg.en && !xfer_i.start && st_r.busy && xfer_i.step
    && st_r.bcnt + 17'h00001 == st_r.bsize |=> blk_end_o && st_r.bcnt == 17'h00000)
    else $error("block boundary missed");
  a_irq_level: assert property ( // RQ17
    irq_o == |(st_r.raw & ~st_r.mask))
    else $error("interrupt level wrong");
  a_lane_code: assert property ( // RQ10
    st_r.cfg.dw == 2'h1 |-> ##1 (st_r.cfg.dw != 2'h1 || card_lines_o == 4'h4))
    else $error("lane count wrong");
endmodule
`default_nettype wire

/* File: rtl/sdh_pkg.sv */
// Package of register map, field layout and carrier types for the card host config block
package sdh_pkg;
  // ****************************
  // Register byte offsets
  // ****************************
  localparam logic [7:0] ADR_RAW = 8'h00; // Latched raw sources, read only
  localparam logic [7:0] ADR_MASK = 8'h04; // Source mask, 1 masks
  localparam logic [7:0] ADR_CLR = 8'h08; // Source clear, write only
  localparam logic [7:0] ADR_RATE = 8'h0C; // Card clock rate
  localparam logic [7:0] ADR_CFG = 8'h10; // Interface configuration
  // ****************************
  // Sizes and reset values
  // ****************************
  localparam int NSRC = 18; // Interrupt sources
  localparam logic [17:0] MASK_RST = 18'h3FFFF; // All sources masked
  localparam logic [31:0] RATE_RST = 32'h80000000; // Clock disabled
  localparam logic [31:0] CFG_RST = 32'h00000000; // All off
  localparam logic [15:0] DIV_MIN = 16'h0002; // Smallest valid divide
  localparam int DLY_TAPS = 16; // Taps of the delay line
  // ****************************
  // Field positions
  // ****************************
  localparam int RATE_DIS = 31; // Clock disable bit
  localparam int RATE_DLY = 16; // Delay field, 4 bits
  localparam int RATE_DIV = 0; // Divider field, 16 bits
  localparam int CFG_DW = 12; // Data width, 2 bits
  localparam int CFG_TXS = 8; // Tx access width, 2 bits
  localparam int CFG_RXS = 6; // Rx access width, 2 bits
  localparam int CFG_EN = 5; // Interface enable
  localparam int CFG_BS = 0; // Block size exponent, 4 bits
  // ****************************
  // Carrier types
  // ****************************
  // Configuration seen by the data path
  typedef struct packed {
    logic [1:0] dw; // Card bus width code
    logic [1:0] txs; // Tx fifo access width code
    logic [1:0] rxs; // Rx fifo access width code
    logic en; // Interface enable
    logic [3:0] bs; // Block size exponent
  } sdh_cfg_t;
  // Transfer chunking request
  typedef struct packed {
    logic start; // Load a new transfer
    logic [15:0] len; // Length in bytes
    logic step; // One byte moved
  } sdh_xfer_t;
endpackage

/* File: bench/sdh_card_model.sv */
// Card side model that measures the serial clock it receives
`timescale 1ns/1ps
`default_nettype none
module sdh_card_model (
  input wire logic clk_i,
  input wire logic card_clk_i,
  output int hi_o,
  output int per_o,
  output int rises_o
);
  int hc = 0; // High samples of this pulse
  int pc = 0; // Samples since last rise
  logic prev = 1'b0; // Clock seen last cycle
  initial hi_o = 0;
  initial per_o = 0;
  initial rises_o = 0;
  // Width of each high pulse and each period, in system clock cycles
  always @(posedge clk_i) begin
    prev <= card_clk_i;
    pc <= pc + 1;
    if (card_clk_i) begin
      hc <= hc + 1;
    end
    if (card_clk_i && !prev) begin
      rises_o <= rises_o + 1;
      per_o <= pc;
      pc <= 1;
    end
    if (!card_clk_i && prev) begin
      hi_o <= hc;
      hc <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: bench/sdh_regs_tb.sv */
// Self-checking bench of the card host config block
`timescale 1ns/1ps
`default_nettype none
module sdh_regs_tb;
  logic clk_i = 1'b0; // System clock
  logic rst_i = 1'b1; // Sync reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'hF; // All lanes
  logic [31:0] rdat; // Last read data
  logic [17:0] src = 18'h00000; // Raw events
  sdh_pkg::sdh_xfer_t xfer = '0; // Chunker request
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, card_clk_o, blk_end_o, xfer_done_o, xfer_busy_o;
  sdh_pkg::sdh_cfg_t cfg_o;
  logic [3:0] card_lines_o;
  logic [16:0] blk_bytes_o;
  int num_errors = 0, num_checks = 0, n_blk = 0, n_done = 0, hi, per, rises;
  always #5 clk_i = ~clk_i;
  sdh_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_evt_i(src), .irq_o(irq_o), .card_clk_o(card_clk_o), .cfg_o(cfg_o),
    .card_lines_o(card_lines_o), .blk_bytes_o(blk_bytes_o), .xfer_i(xfer),
    .blk_end_o(blk_end_o), .xfer_done_o(xfer_done_o), .xfer_busy_o(xfer_busy_o));
  sdh_card_model card (.clk_i(clk_i), .card_clk_i(card_clk_o), .hi_o(hi), .per_o(per),
    .rises_o(rises));
  // Pulse counters, sampled where outputs are settled
  always @(negedge clk_i) begin
    if (blk_end_o === 1'b1) n_blk++;
    if (xfer_done_o === 1'b1) n_done++;
  end
  // ****************************
  // Shared tasks
  // ****************************
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack is sampled at each rising edge, before the edge updates it
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Stop clock, program rate, restart; count cycles to first rise
  task automatic run_clk(input logic [31:0] rate, output int n);
    wb(1'b1, sdh_pkg::ADR_RATE, 32'h80000000 | rate);
    repeat (20) @(posedge clk_i);
    wb(1'b1, sdh_pkg::ADR_RATE, rate);
    n = 0;
    while (card_clk_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    repeat (30) @(posedge clk_i);
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset();
    chk("clk idle", card_clk_o, 32'h0);
    wb(1'b0, sdh_pkg::ADR_RATE, 32'h0);
    chk("rate rst", rdat, 32'h80000000);
    wb(1'b0, sdh_pkg::ADR_MASK, 32'h0);
    chk("mask rst", rdat, 32'h0003FFFF);
    wb(1'b0, sdh_pkg::ADR_CFG, 32'h0);
    chk("cfg rst", rdat, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rdat, 32'h0);
  endtask
  task automatic t_irq();
    @(posedge clk_i);
    src <= 18'h20001;
    @(posedge clk_i);
    src <= 18'h00000;
    wb(1'b0, sdh_pkg::ADR_RAW, 32'h0);
    chk("raw", rdat, 32'h00020001);
    chk("irq masked", irq_o, 32'h0);
    wb(1'b1, sdh_pkg::ADR_MASK, 32'h0001FFFE);
    repeat (2) @(negedge clk_i);
    chk("irq open", irq_o, 32'h1);
    wb(1'b1, sdh_pkg::ADR_CLR, 32'hFFFC0000);
    wb(1'b0, sdh_pkg::ADR_RAW, 32'h0);
    chk("raw kept", rdat, 32'h00020001);
    wb(1'b1, sdh_pkg::ADR_CLR, 32'h00000001);
    repeat (2) @(negedge clk_i);
    chk("irq bit17 on", irq_o, 32'h1);
    wb(1'b1, sdh_pkg::ADR_CLR, 32'h00020000);
    repeat (2) @(negedge clk_i);
    chk("irq clr", irq_o, 32'h0);
    wb(1'b0, sdh_pkg::ADR_RAW, 32'h0);
    chk("raw clr", rdat, 32'h0);
    wb(1'b0, sdh_pkg::ADR_CLR, 32'h0);
    chk("clr read", rdat, 32'h0);
  endtask
  task automatic t_cfg();
    logic [31:0] v;
    logic [1:0] c;
    logic [1:0] nc;
    for (int i = 0; i < 16; i++) begin
      c = i[1:0];
      nc = ~c;
      v = {18'h0, c, 2'b00, c, nc, 1'b1, 1'b0, i[3:0]};
      // Widths change only while no transfer runs, so no fifo needs a flush
      chk("idle on width change", xfer_busy_o, 32'h0);
      wb(1'b1, sdh_pkg::ADR_CFG, v);
      repeat (2) @(negedge clk_i);
      wb(1'b0, sdh_pkg::ADR_CFG, 32'h0);
      chk("cfg", rdat, v);
      chk("lines", card_lines_o, (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 0);
      chk("txs", cfg_o.txs, c);
      chk("rxs", cfg_o.rxs, nc);
      chk("blk", blk_bytes_o, (i == 0) ? 0 : 1 << i);
    end
  endtask
  task automatic t_clock();
    int n0, n1, r;
    wb(1'b1, sdh_pkg::ADR_CFG, 32'h00000020);
    run_clk(32'h00000004, n0);
    chk("per4", per, 32'd4);
    chk("hi4", hi, 32'd2);
    run_clk(32'h00030005, n1);
    chk("per5", per, 32'd5);
    chk("dly", n1 - n0, 32'd3);
    wb(1'b1, sdh_pkg::ADR_RATE, 32'h80030005);
    repeat (20) @(posedge clk_i);
    r = rises;
    repeat (40) @(posedge clk_i);
    chk("stopped", rises, r);
    chk("low", card_clk_o, 32'h0);
    chk("whole hi", hi, 32'd2);
    run_clk(32'h00000001, n0);
    chk("div1", rises, r);
    wb(1'b1, sdh_pkg::ADR_CFG, 32'h00000000);
    run_clk(32'h00000004, n0);
    chk("en off", rises, r);
  endtask
  task automatic t_chunk();
    wb(1'b1, sdh_pkg::ADR_CFG, 32'h00000021);
    n_blk = 0;
    n_done = 0;
    @(posedge clk_i);
    xfer <= {1'b1, 16'h0005, 1'b0};
    repeat (5) begin
      @(posedge clk_i);
      xfer <= {1'b0, 16'h0005, 1'b1};
    end
    @(posedge clk_i);
    xfer <= '0;
    repeat (5) @(posedge clk_i);
    chk("blocks", n_blk, 32'd3);
    chk("done", n_done, 32'd1);
    wb(1'b1, sdh_pkg::ADR_CFG, 32'h00000001);
    @(posedge clk_i);
    xfer <= {1'b1, 16'h0005, 1'b0};
    @(posedge clk_i);
    xfer <= '0;
    repeat (2) @(negedge clk_i);
    chk("refused", xfer_busy_o, 32'h0);
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_irq();
    t_cfg();
    t_clock();
    t_chunk();
    stop_test();
  end
endmodule
`default_nettype wire
